// ==== rpk_defines.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef RPK_DEFINES_SVH
`define RPK_DEFINES_SVH
`define RPK_CLK_HZ 50000000
`define RPK_SAMPLE_HZ 274000
`define RPK_SAMPLE_DIV ((`RPK_CLK_HZ + `RPK_SAMPLE_HZ - 1) / `RPK_SAMPLE_HZ)
`define RPK_REF_STARTUP_US 100
`define RPK_REF_STARTUP_CYC (`RPK_REF_STARTUP_US * (`RPK_CLK_HZ / 1000000))
`define RPK_AVG_SAMPLES 4
`define RPK_OFF_CTRL 8'h00
`define RPK_OFF_RES_HIGH 8'h04
`define RPK_OFF_RES_LOW 8'h08
`define RPK_OFF_STATUS 8'h0c
`define RPK_OFF_PAYLOAD 8'h10
`define RPK_OFF_RECEIVE 8'h14
`define RPK_OFF_WAKEUP 8'h18
`define RPK_OFF_BITDELAY 8'h1c
`define RPK_SEL_RESET 3'h0
`define RPK_DONE_BIT 0
`define RPK_REF_BIT 1
`define RPK_READY_BIT 2
`endif

// ==== rpk_pkg.sv ====
// Types shared by the peak readout design.
package rpk_pkg;
    typedef enum logic [2:0] {
        RPK_SEL_STRENGTH = 3'h0,
        RPK_SEL_TEMP = 3'h1,
        RPK_SEL_SUPPLY = 3'h2
    } rpk_sel_t;
    typedef enum {
        RPK_PL_IDLE,
        RPK_PL_DELAY,
        RPK_PL_OBSERVE
    } rpk_pl_state_t;
endpackage : rpk_pkg

// ==== rpk_peak.sv ====
// One peak tracker that keeps the largest averaged sample seen.
module rpk_peak
    import rpk_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic restart,
    input wire logic observe,
    input wire logic sample_valid,
    input wire logic [9:0] sample,
    output logic [9:0] peak
);
    // Restart clears the tracked peak; larger samples replace it.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            peak <= 10'h000;
        end else if (clk_en) begin
            if (restart) begin
                peak <= 10'h000;
            end else if (observe && sample_valid && sample > peak) begin
                peak <= sample;
            end
        end
    end
    a_peak_monotone: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && !$past(restart) && $past(clk_en)) |-> peak >= $past(peak))
        else $error("Peak value decreased without restart.");
endmodule : rpk_peak

// ==== rpk_avg.sv ====
// Four-sample averager for the signal-strength level.
module rpk_avg
    import rpk_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [9:0] in_data,
    output logic out_valid,
    output logic [9:0] out_data
);
    logic [11:0] acc;
    logic [1:0] cnt;
    logic [11:0] sum;
    assign sum = acc + {2'h0, in_data};
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc <= 12'h000;
            cnt <= 2'h0;
            out_valid <= 1'b0;
            out_data <= 10'h000;
        end else if (clk_en) begin
            out_valid <= 1'b0;
            if (in_valid) begin
                cnt <= cnt + 2'h1;
                if (cnt == 2'h3) begin
                    acc <= 12'h000;
                    out_data <= sum[11:2];
                    out_valid <= 1'b1;
                end else begin
                    acc <= sum;
                end
            end
        end
    end
endmodule : rpk_avg

// ==== rpk_top.sv ====
// Signal-strength converter readout, averager and three peak detectors.
// Functional notes
// - Selector code 0 picks strength, 1 temperature, 2 half supply.
// - Selector resets to the signal-strength input.
// - Leaving strength in low power turns references on; host waits 100us.
// - References stay on until selector returns to strength.
// - Result refreshes about every 3.7us; host reads no faster.
// - A done flag shows a completed conversion.
// - Converter samples at a fixed 274kHz rate.
// - Strength is averaged over four samples before peak detection.
// - Payload detector observes from frame sync plus bit delay to end of message.
// - Payload peak cleared at sync, copied to register at end.
// - Payload observation start is delayed by programmed bit count.
// - Payload peak register cleared only by power-up reset.
// - Receive detector tracks whenever the receiver runs.
// - Reading receive peak refreshes register then restarts detector.
// - With receiver stopped, reads leave the detector unchanged.
// - Receive peak register clears to zero at reset.
// - Wake-up peak starts at zero each configuration, tracks search.
// - On wake-up the tracked peak is written to its register.
// - Without wake-up the peak is written at configuration end.
`include "rpk_defines.svh"
module rpk_top
    import rpk_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] strength_code,
    input wire logic [9:0] temp_code,
    input wire logic [9:0] supply_code,
    input wire logic low_power,
    input wire logic receiver_running,
    input wire logic frame_sync_found,
    input wire logic end_of_message,
    input wire logic data_bit_tick,
    input wire logic wakeup_search,
    input wire logic config_start,
    input wire logic wakeup_found,
    input wire logic config_end,
    output logic [2:0] converter_input_selector,
    output logic reference_enable
);
    localparam logic [7:0] DIV_LAST = 8'(`RPK_SAMPLE_DIV - 1);
    localparam logic [12:0] REF_CYC = 13'(`RPK_REF_STARTUP_CYC);
    logic [2:0] converter_input_select;
    logic [7:0] peak_start_bit_delay, div_cnt, pl_bits, aw_addr;
    logic [9:0] converter_result, avg_data, conv_mux;
    logic [9:0] payload_peak_level, receive_peak_level, wakeup_peak_level;
    logic [9:0] pl_track, rx_track, wu_track;
    logic [12:0] ref_cnt;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sample_tick, conv_done, ref_on, ref_ready, avg_valid;
    logic pl_restart, rx_restart, aw_held, w_held;
    logic do_write, rd_take, rd_rx_peak;
    rpk_pl_state_t pl_state;
    // The pins mirror the control field and the reference state.
    assign converter_input_selector = converter_input_select;
    assign reference_enable = ref_on;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_cnt <= 8'h00;
        end else if (clk_en) begin
            div_cnt <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
        end
    end
    assign sample_tick = (div_cnt == DIV_LAST);
    always_comb begin
        case (converter_input_select)
            RPK_SEL_STRENGTH: conv_mux = strength_code;
            RPK_SEL_TEMP: conv_mux = temp_code;
            RPK_SEL_SUPPLY: conv_mux = supply_code;
            default: conv_mux = 10'h000;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            converter_result <= 10'h000;
            conv_done <= 1'b0;
        end else if (clk_en) begin
            if (sample_tick) begin
                converter_result <= conv_mux;
            end
            // Set wins over the clear made by reading the high result.
            if (sample_tick) begin
                conv_done <= 1'b1;
            end else if (rd_take &&
                    s_axi_araddr[7:0] == `RPK_OFF_RES_HIGH) begin
                conv_done <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ref_on <= 1'b0;
            ref_cnt <= 13'h0000;
        end else if (clk_en) begin
            if (converter_input_select != RPK_SEL_STRENGTH && low_power) begin
                ref_on <= 1'b1;
            end else if (converter_input_select == RPK_SEL_STRENGTH) begin
                ref_on <= 1'b0;
            end
            if (!ref_on) begin
                ref_cnt <= 13'h0000;
            end else if (ref_cnt != REF_CYC) begin
                ref_cnt <= ref_cnt + 13'h0001;
            end
        end
    end
    assign ref_ready = ref_on && (ref_cnt == REF_CYC);
    rpk_avg u_avg (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(sample_tick && converter_input_select == RPK_SEL_STRENGTH),
        .in_data(conv_mux),
        .out_valid(avg_valid),
        .out_data(avg_data)
    );
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pl_state <= RPK_PL_IDLE;
            pl_bits <= 8'h00;
        end else if (clk_en) begin
            case (pl_state)
                RPK_PL_IDLE: begin
                    if (frame_sync_found) begin
                        pl_bits <= peak_start_bit_delay;
                        pl_state <= (peak_start_bit_delay == 8'h00) ?
                            RPK_PL_OBSERVE : RPK_PL_DELAY;
                    end
                end
                RPK_PL_DELAY: begin
                    if (end_of_message) begin
                        pl_state <= RPK_PL_IDLE;
                    end else if (data_bit_tick) begin
                        pl_bits <= pl_bits - 8'h01;
                        if (pl_bits == 8'h01) begin
                            pl_state <= RPK_PL_OBSERVE;
                        end
                    end
                end
                RPK_PL_OBSERVE: begin
                    if (end_of_message) begin
                        pl_state <= RPK_PL_IDLE;
                    end
                end
                default: pl_state <= RPK_PL_IDLE;
            endcase
        end
    end
    assign pl_restart = frame_sync_found && pl_state == RPK_PL_IDLE;
    rpk_peak u_pl (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .restart(pl_restart),
        .observe(pl_state == RPK_PL_OBSERVE),
        .sample_valid(avg_valid),
        .sample(avg_data),
        .peak(pl_track)
    );
    assign rd_rx_peak = rd_take && s_axi_araddr[7:0] == `RPK_OFF_RECEIVE;
    assign rx_restart = rd_rx_peak && receiver_running;
    rpk_peak u_rx (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .restart(rx_restart),
        .observe(receiver_running),
        .sample_valid(avg_valid),
        .sample(avg_data),
        .peak(rx_track)
    );
    rpk_peak u_wu (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .restart(config_start),
        .observe(wakeup_search),
        .sample_valid(avg_valid),
        .sample(avg_data),
        .peak(wu_track)
    );
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            payload_peak_level <= 10'h000;
        end else if (clk_en && pl_state != RPK_PL_IDLE && end_of_message) begin
            payload_peak_level <= pl_track;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            receive_peak_level <= 10'h000;
        end else if (clk_en && rd_rx_peak) begin
            receive_peak_level <= rx_track;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wakeup_peak_level <= 10'h000;
        end else if (clk_en && (wakeup_found || config_end)) begin
            wakeup_peak_level <= wu_track;
        end
    end

    // Write channel: address and data taken in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == `RPK_OFF_CTRL ||
                    aw_addr == `RPK_OFF_BITDELAY) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            converter_input_select <= `RPK_SEL_RESET;
            peak_start_bit_delay <= 8'h00;
        end else if (clk_en && do_write && w_strb[0]) begin
            if (aw_addr == `RPK_OFF_CTRL) begin
                converter_input_select <= w_data[2:0];
            end
            if (aw_addr == `RPK_OFF_BITDELAY) begin
                peak_start_bit_delay <= w_data[7:0];
            end
        end
    end

    // Read channel: one cycle from address taken to data valid.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready && clk_en;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (clk_en) begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr[7:0])
                    `RPK_OFF_CTRL:
                        s_axi_rdata <= {29'h0, converter_input_select};
                    // high result holds top eight bits
                    `RPK_OFF_RES_HIGH:
                        s_axi_rdata <= {24'h0, converter_result[9:2]};
                    `RPK_OFF_RES_LOW:
                        s_axi_rdata <= {30'h0, converter_result[1:0]};
                    `RPK_OFF_STATUS: s_axi_rdata <= {29'h0, ref_ready, ref_on,
                        conv_done};
                    `RPK_OFF_PAYLOAD:
                        s_axi_rdata <= {22'h0, payload_peak_level};
                    `RPK_OFF_RECEIVE: s_axi_rdata <= {22'h0, rx_track};
                    `RPK_OFF_WAKEUP: s_axi_rdata <= {22'h0, wakeup_peak_level};
                    `RPK_OFF_BITDELAY:
                        s_axi_rdata <= {24'h0, peak_start_bit_delay};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_sample_rate: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && sample_tick) |=> !sample_tick [*8])
        else $error("Converter samples too close together.");
    a_ref_enable: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && low_power && converter_input_select != RPK_SEL_STRENGTH)
        |=> ref_on)
        else $error("References not enabled outside strength input.");
    a_ref_release: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && converter_input_select == RPK_SEL_STRENGTH) |=> !ref_on)
        else $error("References stayed on with strength selected.");
    a_payload_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !$past(end_of_message) |-> $stable(payload_peak_level))
        else $error("Payload peak changed without end of message.");
    a_rx_restart: assert property (@(posedge ref_clk) disable iff (reset)
        rx_restart |=> rx_track == 10'h000 &&
            receive_peak_level == $past(rx_track))
        else $error("Receive peak read did not refresh and restart.");
    a_rx_stopped: assert property (@(posedge ref_clk) disable iff (reset)
        (!receiver_running && clk_en) |=> $stable(rx_track))
        else $error("Receive detector changed while stopped.");
    a_wu_capture: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && wakeup_found) |=> wakeup_peak_level == $past(wu_track))
        else $error("Wake-up peak not captured.");
    a_done_set: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && sample_tick) |=> conv_done)
        else $error("Done flag missing after conversion.");
endmodule : rpk_top

// ==== rpk_host_model.sv ====
// Host model that runs AXI4-Lite cycles towards the readout block.
module rpk_host_model (
    input wire logic ref_clk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    // read spacing: 3.7 us at 50 MHz between reads.
    localparam int READ_GAP = 185;
    localparam int BUS_LIMIT = 64;
    // Response code of the most recent write, kept for the bench.
    logic [1:0] last_bresp;

    // The bus is idle from time zero.
    initial begin
        s_axi_awaddr = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // One write; each channel is released at the edge that takes it.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < BUS_LIMIT && !done; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                last_bresp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) test_signal_strength_level_peak_and_adc_readout.give_up();
    endtask : bus_write

    // One read, taking data and response at the edge with rvalid high.
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic done;
        done = 1'b0;
        // read spacing: a host never reads back to back.
        repeat (READ_GAP) @(posedge ref_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < BUS_LIMIT && !done; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) test_signal_strength_level_peak_and_adc_readout.give_up();
    endtask : bus_read
endmodule : rpk_host_model

// ==== test_signal_strength_level_peak_and_adc_readout.sv ====
// Self-checking bench for the signal-strength readout block.
`include "rpk_defines.svh"
module test_signal_strength_level_peak_and_adc_readout;
    timeunit 1ns;
    timeprecision 100ps;
    // Long enough for a clean four-sample average after any change.
    localparam int SETTLE = 3 * `RPK_SAMPLE_DIV * `RPK_AVG_SAMPLES;
    logic ref_clk, reset, clk_en, low_power, receiver_running;
    logic wakeup_search;
    logic [5:0] ev;
    logic [9:0] strength_code, temp_code, supply_code;
    logic [2:0] converter_input_selector;
    logic reference_enable;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [9:0] codes [3];
    logic [2:0] order [3];
    int miscompares = 0;
    int comparisons = 0;

    rpk_top u_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .strength_code(strength_code), .temp_code(temp_code),
        .supply_code(supply_code), .low_power(low_power),
        .receiver_running(receiver_running), .frame_sync_found(ev[0]),
        .end_of_message(ev[1]), .data_bit_tick(ev[2]),
        .wakeup_search(wakeup_search), .config_start(ev[3]),
        .wakeup_found(ev[4]), .config_end(ev[5]),
        .converter_input_selector(converter_input_selector),
        .reference_enable(reference_enable));

    rpk_host_model u_host (.ref_clk(ref_clk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Ends the run when a bounded wait runs out.
    task automatic give_up();
        miscompares++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        complete_run();
    endtask : give_up

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
        end
    endtask : check

    // Reads one register and compares it.
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                            input string what);
        u_host.bus_read(a, rd, rr);
        check(rd, exp, what);
    endtask : rd_check

    // Polls a status bit with a bounded number of reads.
    task automatic wait_bit(input int b);
        for (int n = 0; n < 60; n++) begin
            u_host.bus_read(`RPK_OFF_STATUS, rd, rr);
            if (rd[b] === 1'b1) return;
        end
        give_up();
    endtask : wait_bit

    // One-cycle pulse on one event input, then one quiet cycle.
    task automatic pulse(input int k);
        ev <= 6'h1 << k;
        @(posedge ref_clk);
        ev <= 6'h0;
        @(posedge ref_clk);
    endtask : pulse

    // Main sequence.
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        low_power = 1'b0;
        receiver_running = 1'b0;
        wakeup_search = 1'b0;
        ev = 6'h0;
        codes = '{10'h2a5, 10'h1c6, 10'h3f1};
        order = '{3'h1, 3'h2, 3'h0};
        strength_code = codes[0];
        temp_code = codes[1];
        supply_code = codes[2];
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd_check(`RPK_OFF_CTRL, 32'h0, "selector reset");
        rd_check(`RPK_OFF_RECEIVE, 32'h0, "receive reset");
        rd_check(`RPK_OFF_PAYLOAD, 32'h0, "payload reset");
        low_power <= 1'b1;
        foreach (order[i]) begin
            u_host.bus_write(`RPK_OFF_CTRL, {29'h0, order[i]});
            check({30'h0, u_host.last_bresp}, 32'h0, "write ok");
            repeat (3) @(posedge ref_clk);
            check({29'h0, converter_input_selector}, {29'h0, order[i]},
                  "selector out");
            check({31'h0, reference_enable}, {31'h0, order[i] != 3'h0},
                  "references");
            rd_check(`RPK_OFF_CTRL, {29'h0, order[i]}, "ctrl back");
            if (order[i] == 3'h0) low_power <= 1'b0;
            else wait_bit(`RPK_READY_BIT);
            u_host.bus_read(`RPK_OFF_RES_HIGH, rd, rr);
            wait_bit(`RPK_DONE_BIT);
            rd_check(`RPK_OFF_RES_HIGH, {24'h0, codes[order[i]][9:2]},
                     "result");
        end
        receiver_running <= 1'b1;
        strength_code <= 10'h3c0;
        u_host.bus_read(`RPK_OFF_RECEIVE, rd, rr);
        repeat (SETTLE) @(posedge ref_clk);
        rd_check(`RPK_OFF_RECEIVE, 32'h3c0, "receive peak");
        repeat (SETTLE) @(posedge ref_clk);
        strength_code <= 10'h120;
        repeat (SETTLE) @(posedge ref_clk);
        rd_check(`RPK_OFF_RECEIVE, 32'h3c0, "held peak");
        repeat (SETTLE) @(posedge ref_clk);
        receiver_running <= 1'b0;
        rd_check(`RPK_OFF_RECEIVE, 32'h120, "restarted");
        rd_check(`RPK_OFF_RECEIVE, 32'h120, "stopped 1");
        rd_check(`RPK_OFF_RECEIVE, 32'h120, "stopped 2");
        u_host.bus_write(`RPK_OFF_BITDELAY, 32'h2);
        strength_code <= 10'h3ff;
        pulse(0);
        repeat (SETTLE) @(posedge ref_clk);
        strength_code <= 10'h0f0;
        repeat (SETTLE) @(posedge ref_clk);
        repeat (2) pulse(2);
        repeat (SETTLE) @(posedge ref_clk);
        pulse(1);
        repeat (2) @(posedge ref_clk);
        rd_check(`RPK_OFF_PAYLOAD, 32'h0f0, "payload");
        u_host.bus_write(`RPK_OFF_PAYLOAD, 32'h5);
        check({30'h0, u_host.last_bresp}, 32'h2, "write resp");
        rd_check(`RPK_OFF_PAYLOAD, 32'h0f0, "payload kept");
        wakeup_search <= 1'b1;
        pulse(3);
        strength_code <= 10'h300;
        repeat (SETTLE) @(posedge ref_clk);
        pulse(4);
        repeat (2) @(posedge ref_clk);
        rd_check(`RPK_OFF_WAKEUP, 32'h300, "wake-up");
        strength_code <= 10'h080;
        repeat (SETTLE) @(posedge ref_clk);
        pulse(3);
        repeat (SETTLE) @(posedge ref_clk);
        pulse(5);
        repeat (2) @(posedge ref_clk);
        rd_check(`RPK_OFF_WAKEUP, 32'h080, "config end");
        clk_en <= 1'b0;
        pulse(3);
        clk_en <= 1'b1;
        pulse(4);
        rd_check(`RPK_OFF_WAKEUP, 32'h080, "frozen");
        u_host.bus_read(8'h40, rd, rr);
        check({30'h0, rr}, 32'h2, "unmapped resp");
        check(rd, 32'h0, "unmapped data");
        complete_run();
    end
endmodule : test_signal_strength_level_peak_and_adc_readout
